//--- reset_seq_defines.svh
// Constants of the reset source and pin reset controller
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

`define CLK_HZ           (64'd10000000)
`define STAB_TIME_US     (64'd2000)
`define WDT_HOLD_TIME_US (64'd20)
`define STAB_CYCLES_DFLT \
  ((`STAB_TIME_US * `CLK_HZ + 64'd999999) / 64'd1000000)
`define WDT_HOLD_CYCLES \
  ((`WDT_HOLD_TIME_US * `CLK_HZ + 64'd999999) / 64'd1000000)
`define CNT_W            24

`define ADDR_PROT        32'hfffff880
`define ADDR_BITOP       32'hfffff884
`define ADDR_FLAGS       32'hfffff888
`define ADDR_DBG         32'hfffff88c
`define ADDR_CLKSEL      32'hfffff890
`define ADDR_STATUS      32'hfffff894

`define PROT_KEY         8'ha5
`define LVD_FLAG_BIT     0
`define CLM_FLAG_BIT     1
`define WDT_FLAG_BIT     4
`define FLAGS_MASK       8'h13
`define FLAGS_RST        8'h00
`define DBG_RST          8'h01
`define DBG_EN_BIT       0
`define DIV8_CODE        3'h3
`define BITOP_VAL_BIT    3
`define ST_EMERG_BIT     3
`define ST_RAM_BIT       4
`define ST_DBG_BIT       5

`endif

//--- reset_seq_pkg.sv
// Types of the reset source and pin reset controller
`include "reset_seq_defines.svh"

package reset_seq_pkg;

  typedef enum logic [2:0] {
    ST_PIN_HOLD   = 3'b000,
    ST_TIMED_HOLD = 3'b001,
    ST_LVD_HOLD   = 3'b010,
    ST_STAB       = 3'b011,
    ST_RUN        = 3'b100
  } seq_state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic       sys_reset_n;
    logic       periph_reg_reset_n;
    logic       lvd_reset_n;
    logic       main_osc_en;
    logic       int_osc_en;
    logic       sub_osc_en;
    logic       clk_run;
    logic       cpu_run;
    logic       periph_run;
    logic       wdt_hold;
    logic       cpu_on_int_osc;
    logic       ram_corrupt;
    logic       debug_mode;
    logic [2:0] div_sel;
  } ctl_type;

  typedef struct packed {
    seq_state_type          state;
    logic [`CNT_W-1:0]      cnt;
    logic [7:0]             flags;
    logic [7:0]             dbg_ctl;
    logic [2:0]             div_sel;
    logic                   armed;
    logic                   emerg;
    logic                   ram_bad;
    logic                   dbg_mode;
    logic [1:0]             pin_sync;
    logic [1:0]             debug_reset_pin_sync;
    logic [31:0]            prdata;
    logic                   pslverr;
    ctl_type                out;
  } state_type;

endpackage

//--- reset_source_and_pin_reset.sv
// Reset source flags, pin reset and post-reset start-up sequencer
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
`include "reset_seq_defines.svh"

module reset_source_and_pin_reset #(
  parameter int unsigned STAB_CYCLES = int'(`STAB_CYCLES_DFLT)
) (
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire reset_seq_pkg::apb_req_type apb_req,
  output      reset_seq_pkg::apb_rsp_type apb_rsp,
  input  wire logic                       reset_pin_n,
  input  wire logic                       debug_reset_pin,
  input  wire logic                       watchdog_reset_signal,
  input  wire logic                       clock_monitor_reset_req,
  input  wire logic                       low_voltage_reset_req,
  input  wire logic                       cpu_mem_access,
  output      reset_seq_pkg::ctl_type     ctl
);

  localparam int CW = `CNT_W;
  localparam logic [CW-1:0] STAB_LAST = CW'(STAB_CYCLES - 1);
  localparam logic [CW-1:0] HOLD_LAST =
    CW'(`WDT_HOLD_CYCLES - 64'd1);

  if (STAB_CYCLES < 1 || STAB_CYCLES > (1 << CW)) begin : g_chk
    $error("STAB_CYCLES does not fit the counter");
  end

  reset_seq_pkg::state_type q;
  reset_seq_pkg::state_type n;

  logic       pin_low;
  logic       setup;
  logic       wr_acc;
  logic       run_like;
  logic       wdt_rst;
  logic       clm_rst;
  logic       lvd_rst;
  logic       enter_rst;
  logic       in_reset;
  logic [7:0] set_mask;
  logic [7:0] status;

  always_comb begin
    n = q;
    // Pin inputs pass two flip-flops before any use
    n.pin_sync  = {q.pin_sync[0], reset_pin_n};
    n.debug_reset_pin_sync = {q.debug_reset_pin_sync[0], debug_reset_pin};
    pin_low  = ~q.pin_sync[1];
    setup    = apb_req.psel & ~apb_req.penable;
    wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;
    run_like = (q.state == reset_seq_pkg::ST_RUN) ||
               (q.state == reset_seq_pkg::ST_STAB);
    status   = 8'h00;
    status[2:0] = q.state;
    status[`ST_EMERG_BIT] = q.emerg;
    status[`ST_RAM_BIT]   = q.ram_bad;
    status[`ST_DBG_BIT]   = q.dbg_mode;

    // Register reads are captured in the setup phase
    if (setup) begin
      n.pslverr = 1'b0;
      n.prdata  = 32'h00000000;
      case (apb_req.paddr)
        `ADDR_PROT:   n.prdata = {31'h00000000, q.armed};
        `ADDR_BITOP:  n.prdata = 32'h00000000;
        `ADDR_FLAGS:  n.prdata = {24'h000000, q.flags};
        `ADDR_DBG:    n.prdata = {24'h000000, q.dbg_ctl};
        `ADDR_CLKSEL: n.prdata = {29'h00000000, q.div_sel};
        `ADDR_STATUS: n.prdata = {24'h000000, status};
        default:      n.pslverr = 1'b1;
      endcase
    end

    // Any completed write disarms the key; the flag write must be next
    if (wr_acc) begin
      n.armed = 1'b0;
      case (apb_req.paddr)
        `ADDR_PROT: begin
          if (apb_req.pstrb[0] && apb_req.pwdata[7:0] == `PROT_KEY) begin
            n.armed = 1'b1;
          end
        end
        `ADDR_FLAGS: begin
          if (q.armed && apb_req.pstrb[0]) begin
            n.flags = q.flags & apb_req.pwdata[7:0] & `FLAGS_MASK;
          end
        end
        `ADDR_BITOP: begin
          // Single-bit access: index in [2:0], value in bit 3
          if (q.armed && apb_req.pstrb[0] &&
              !apb_req.pwdata[`BITOP_VAL_BIT]) begin
            n.flags[apb_req.pwdata[2:0]] = 1'b0;
          end
        end
        `ADDR_DBG: begin
          if (apb_req.pstrb[0]) begin
            n.dbg_ctl = {7'h00, apb_req.pwdata[`DBG_EN_BIT]};
          end
        end
        `ADDR_CLKSEL: begin
          if (apb_req.pstrb[0]) begin
            n.div_sel = apb_req.pwdata[2:0];
          end
        end
        `ADDR_STATUS: begin
          if (apb_req.pstrb[0] && apb_req.pwdata[`ST_RAM_BIT]) begin
            n.ram_bad = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // A watchdog overflow in the stabilization wait is no reset
    wdt_rst = watchdog_reset_signal &
              (q.state == reset_seq_pkg::ST_RUN);
    clm_rst = clock_monitor_reset_req & run_like;
    lvd_rst = low_voltage_reset_req & run_like;

    case (q.state)
      reset_seq_pkg::ST_PIN_HOLD: begin
        if (!pin_low) begin
          n.state = reset_seq_pkg::ST_STAB;
          n.cnt   = '0;
        end
      end
      reset_seq_pkg::ST_TIMED_HOLD: begin
        if (q.cnt == HOLD_LAST) begin
          n.state = reset_seq_pkg::ST_STAB;
          n.cnt   = '0;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      reset_seq_pkg::ST_LVD_HOLD: begin
        if (!low_voltage_reset_req) begin
          n.state = reset_seq_pkg::ST_STAB;
          n.cnt   = '0;
        end
      end
      reset_seq_pkg::ST_STAB: begin
        if (watchdog_reset_signal) begin
          n.emerg = 1'b1;
          n.state = reset_seq_pkg::ST_RUN;
          n.cnt   = '0;
        end else if (q.cnt == STAB_LAST) begin
          n.state = reset_seq_pkg::ST_RUN;
          n.cnt   = '0;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      reset_seq_pkg::ST_RUN: begin
        if (q.dbg_ctl[`DBG_EN_BIT] && q.debug_reset_pin_sync[1]) begin
          n.dbg_mode = 1'b1;
        end
      end
      default: begin
        n.state = reset_seq_pkg::ST_PIN_HOLD;
        n.cnt   = '0;
      end
    endcase

    // Flags are set after the software clear, so a set wins
    set_mask = 8'h00;
    set_mask[`WDT_FLAG_BIT] = wdt_rst;
    set_mask[`CLM_FLAG_BIT] = clm_rst;
    set_mask[`LVD_FLAG_BIT] = lvd_rst;
    n.flags = n.flags | set_mask;

    enter_rst = wdt_rst | clm_rst | lvd_rst;
    if (enter_rst) begin
      n.cnt   = '0;
      n.state = lvd_rst ? reset_seq_pkg::ST_LVD_HOLD
                        : reset_seq_pkg::ST_TIMED_HOLD;
      n.emerg   = 1'b0;
      n.armed   = 1'b0;
      n.div_sel = `DIV8_CODE;
      // Debug control survives internal resets
    end

    if (pin_low) begin
      n.state    = reset_seq_pkg::ST_PIN_HOLD;
      n.cnt      = '0;
      n.flags    = `FLAGS_RST;
      n.dbg_ctl  = `DBG_RST;
      n.dbg_mode = 1'b0;
      n.emerg    = 1'b0;
      n.armed    = 1'b0;
      n.div_sel  = `DIV8_CODE;
    end

    // A CPU memory cycle cut by reset assertion damages RAM
    if ((enter_rst || pin_low) && run_like && cpu_mem_access) begin
      n.ram_bad = 1'b1;
    end

    in_reset = (n.state == reset_seq_pkg::ST_PIN_HOLD) ||
               (n.state == reset_seq_pkg::ST_TIMED_HOLD) ||
               (n.state == reset_seq_pkg::ST_LVD_HOLD);
    n.out.sys_reset_n        = ~in_reset;
    n.out.periph_reg_reset_n = ~in_reset;
    // The detector stays alive through a reset it raised itself
    n.out.lvd_reset_n =
      ~((n.state == reset_seq_pkg::ST_PIN_HOLD) ||
        (n.state == reset_seq_pkg::ST_TIMED_HOLD));
    n.out.main_osc_en = ~in_reset;
    n.out.int_osc_en  = ~in_reset;
    n.out.sub_osc_en  = 1'b1;
    n.out.clk_run    = (n.state == reset_seq_pkg::ST_RUN);
    n.out.cpu_run    = (n.state == reset_seq_pkg::ST_RUN);
    n.out.periph_run = (n.state == reset_seq_pkg::ST_RUN);
    // Watchdog restarts from zero on the internal osc after release
    n.out.wdt_hold = in_reset;
    // Software must keep off wait-state registers while this is set
    n.out.cpu_on_int_osc = n.emerg;
    n.out.ram_corrupt    = n.ram_bad;
    n.out.debug_mode     = n.dbg_mode;
    n.out.div_sel        = n.div_sel;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{
        state:     reset_seq_pkg::ST_PIN_HOLD,
        cnt:       '0,
        flags:     `FLAGS_RST,
        dbg_ctl:   `DBG_RST,
        div_sel:   `DIV8_CODE,
        armed:     1'b0,
        emerg:     1'b0,
        ram_bad:   1'b1,
        dbg_mode:  1'b0,
        pin_sync:  2'h0,
        debug_reset_pin_sync: 2'h0,
        prdata:    32'h00000000,
        pslverr:   1'b0,
        out:       '{
          sys_reset_n:        1'b0,
          periph_reg_reset_n: 1'b0,
          lvd_reset_n:        1'b0,
          main_osc_en:        1'b0,
          int_osc_en:         1'b0,
          sub_osc_en:         1'b1,
          clk_run:            1'b0,
          cpu_run:            1'b0,
          periph_run:         1'b0,
          wdt_hold:           1'b1,
          cpu_on_int_osc:     1'b0,
          ram_corrupt:        1'b1,
          debug_mode:         1'b0,
          div_sel:            `DIV8_CODE
        }
      };
    end else begin
      q <= n;
    end
  end

  // Zero-wait slave: data was captured in the setup phase
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pslverr = q.pslverr & apb_req.psel & apb_req.penable;
  assign ctl             = q.out;

endmodule

//--- reset_seq_asserts.sv
// Checker of the reset sequencer outputs against their causes
`timescale 1ns/10ps
`include "reset_seq_defines.svh"
module reset_seq_asserts #(
  parameter int unsigned STAB_CYCLES = 20
) (
  input wire logic                       clk,
  input wire logic                       arst_n,
  input wire reset_seq_pkg::apb_req_type apb_req,
  input wire reset_seq_pkg::apb_rsp_type apb_rsp,
  input wire logic                       reset_pin_n,
  input wire logic                       debug_reset_pin,
  input wire logic                       watchdog_reset_signal,
  input wire logic                       clock_monitor_reset_req,
  input wire logic                       low_voltage_reset_req,
  input wire logic                       cpu_mem_access,
  input wire reset_seq_pkg::ctl_type     ctl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Pin must be high for three samples so the synchroniser is clean
  logic pin_ok;
  assign pin_ok = reset_pin_n;
  // The stabilization check counts eight cycles of the wait
  if (STAB_CYCLES < 8) begin : g_chk
    $error("STAB_CYCLES too short for the checker");
  end
  a_wdt_reset: assert property (ctl.clk_run && watchdog_reset_signal
    |=> !ctl.sys_reset_n) else $error("watchdog did not reset");
  a_sub_osc: assert property (ctl.sub_osc_en)
    else $error("subclock stopped");
  a_hold_state: assert property (!ctl.sys_reset_n |->
    !ctl.periph_reg_reset_n && !ctl.main_osc_en && !ctl.int_osc_en &&
    ctl.wdt_hold && !ctl.cpu_run) else $error("hold state outputs wrong");
  a_run_gate: assert property (ctl.cpu_run || ctl.periph_run |->
    ctl.sys_reset_n && ctl.clk_run) else $error("run while held");
  a_stab_wait: assert property ($rose(ctl.sys_reset_n) |->
    !ctl.clk_run [*8]) else $error("clock ran early");
  a_pin_hold: assert property (!reset_pin_n [*4] |-> !ctl.sys_reset_n)
    else $error("pin low but not in reset");
  a_div_init: assert property (!ctl.sys_reset_n |->
    ctl.div_sel == `DIV8_CODE) else $error("divider not /8");
  a_lvd_keep: assert property (ctl.clk_run && low_voltage_reset_req &&
    pin_ok && $past(pin_ok) && $past(pin_ok, 2) |=> !ctl.sys_reset_n &&
    ctl.lvd_reset_n) else $error("detector reset by itself");
  a_emerg_mode: assert property (ctl.sys_reset_n && !ctl.clk_run &&
    watchdog_reset_signal && !low_voltage_reset_req &&
    !clock_monitor_reset_req && pin_ok && $past(pin_ok) &&
    $past(pin_ok, 2) |=> ctl.cpu_on_int_osc && ctl.sys_reset_n)
    else $error("no internal osc fallback");
endmodule

bind reset_source_and_pin_reset reset_seq_asserts #(
  .STAB_CYCLES(STAB_CYCLES)
) i_reset_seq_asserts (.clk(clk), .arst_n(arst_n), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .reset_pin_n(reset_pin_n),
  .debug_reset_pin(debug_reset_pin),
  .watchdog_reset_signal(watchdog_reset_signal),
  .clock_monitor_reset_req(clock_monitor_reset_req),
  .low_voltage_reset_req(low_voltage_reset_req),
  .cpu_mem_access(cpu_mem_access), .ctl(ctl));

//--- reset_supervisor.sv
// External supervisor that pulls the reset pin low for a while
`timescale 1ns/10ps
module reset_supervisor #(
  parameter int HOLD = 6
) (
  input  wire logic clk,
  input  wire logic trigger,
  output      logic reset_pin_n
);
  int cnt = 0;
  always @(posedge clk) begin
    if (trigger && cnt == 0) cnt <= HOLD;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // Low while counting, then a clean low-to-high edge releases
  assign reset_pin_n = (cnt == 0);
endmodule

//--- reset_source_and_pin_reset_test.sv
// Self-checking bench of the reset source and pin reset block
`timescale 1ns/10ps
`include "reset_seq_defines.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", n, e, g); end end
module reset_source_and_pin_reset_test;
  logic clk = 0, arst_n = 0, dbg = 0, wdt = 0, clock_monitor = 0, lvd = 0;
  logic mem = 0, trig = 0, err;
  logic [31:0] rd, d;
  logic [7:0]  run_code;
  wire logic   pin_n;
  int          miscompares = 0, total_checks = 0, cyc = 0;
  reset_seq_pkg::apb_req_type req = '0;
  reset_seq_pkg::apb_rsp_type rsp;
  reset_seq_pkg::ctl_type     ctl;
  reset_source_and_pin_reset #(
    .STAB_CYCLES(20)
  ) i_reset_source_and_pin_reset (
    .clk(clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
    .reset_pin_n(pin_n), .debug_reset_pin(dbg),
    .watchdog_reset_signal(wdt), .clock_monitor_reset_req(clock_monitor),
    .low_voltage_reset_req(lvd), .cpu_mem_access(mem), .ctl(ctl));
  reset_supervisor i_reset_supervisor (
    .clk(clk), .trigger(trig), .reset_pin_n(pin_n));
  initial forever #50 clk = ~clk;
  function automatic logic [7:0] fw(input logic [7:0] o, logic [31:0] v);
    return o & v[7:0] & `FLAGS_MASK;
  endfunction
  task automatic apb(input logic w, input logic [31:0] a, v);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, v, 4'hf};
    @(posedge clk);
    req.penable <= 1'b1;
    // Wait for the answer; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rchk(input string n, input logic [31:0] a, logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd[7:0])
  endtask
  // Key write must be the last completed write before the target
  task automatic pw(input logic [31:0] a, v);
    apb(1'b1, `ADDR_PROT, {24'h0, `PROT_KEY});
    apb(1'b1, a, v);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {trig, wdt, clock_monitor, lvd} <= m;
    @(posedge clk);
    {trig, wdt, clock_monitor, lvd} <= 4'h0;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while (ctl.clk_run !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
    `CHK("run", 1'b1, ctl.clk_run)
  endtask
  task automatic end_test(input string n);
    $display("test %s done", n);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    void'($urandom(8));
    run_code = 8'(reset_seq_pkg::ST_RUN);
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    wait_run();
    rchk("flags", `ADDR_FLAGS, `FLAGS_RST);
    rchk("dbg", `ADDR_DBG, `DBG_RST);
    rchk("clksel", `ADDR_CLKSEL, {5'h0, `DIV8_CODE});
    rchk("ram", `ADDR_STATUS, 8'h10 | run_code);
    apb(1'b1, `ADDR_STATUS, 32'h10);
    rchk("ramclr", `ADDR_STATUS, run_code);
    end_test("power_on");
    pulse(4'b0100);
    wait_run();
    rchk("wdtflag", `ADDR_FLAGS, 8'h10);
    rchk("ramkept", `ADDR_STATUS, run_code);
    apb(1'b1, `ADDR_FLAGS, 32'h0);
    rchk("unkeyed", `ADDR_FLAGS, 8'h10);
    pw(`ADDR_FLAGS, 32'hff);
    rchk("ones", `ADDR_FLAGS, 8'h10);
    d = $urandom;
    pw(`ADDR_FLAGS, d);
    rchk("andw", `ADDR_FLAGS, fw(8'h10, d));
    pw(`ADDR_FLAGS, 32'h0);
    end_test("watchdog");
    pulse(4'b0010);
    wait_run();
    @(posedge clk);
    lvd <= 1'b1;
    repeat (5 + $urandom % 10) @(posedge clk);
    `CHK("lvdkeep", 1'b1, ctl.lvd_reset_n)
    lvd <= 1'b0;
    wait_run();
    rchk("both", `ADDR_FLAGS, 8'h03);
    pw(`ADDR_BITOP, 32'h1);
    rchk("bitclr", `ADDR_FLAGS, 8'h01);
    pw(`ADDR_BITOP, 32'hc);
    rchk("bitone", `ADDR_FLAGS, 8'h01);
    apb(1'b1, `ADDR_PROT, {24'h0, `PROT_KEY});
    fork
      apb(1'b1, `ADDR_FLAGS, 32'h0);
      begin repeat (2) @(posedge clk); clock_monitor <= 1'b1; @(posedge clk);
        clock_monitor <= 1'b0; end
    join
    wait_run();
    rchk("setwins", `ADDR_FLAGS, 8'h02);
    end_test("flags");
    pulse(4'b0010);
    repeat (2) @(posedge clk);
    while (ctl.sys_reset_n !== 1'b1 && cyc < 19000) @(posedge clk);
    repeat (10) @(posedge clk);
    pulse(4'b0100);
    @(posedge clk);
    `CHK("emerg", 1'b1, ctl.cpu_on_int_osc)
    // Only zero-wait registers are touched while on the internal osc
    rchk("noflag", `ADDR_FLAGS, 8'h02);
    rchk("emergst", `ADDR_STATUS, 8'h08 | run_code);
    apb(1'b1, `ADDR_CLKSEL, 32'h5);
    rchk("clkset", `ADDR_CLKSEL, 8'h05);
    end_test("emergency");
    apb(1'b1, `ADDR_DBG, 32'h0);
    mem <= 1'b1;
    pulse(4'b1000);
    while (ctl.sys_reset_n !== 1'b0 && cyc < 19000) @(posedge clk);
    mem <= 1'b0;
    wait_run();
    rchk("pinclr", `ADDR_FLAGS, 8'h00);
    rchk("dbgset", `ADDR_DBG, `DBG_RST);
    rchk("clkinit", `ADDR_CLKSEL, {5'h0, `DIV8_CODE});
    rchk("ramhit", `ADDR_STATUS, 8'h10 | run_code);
    `CHK("ramout", 1'b1, ctl.ram_corrupt)
    dbg <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("dbgmode", 1'b1, ctl.debug_mode)
    apb(1'b0, 32'hfffff8a0, 32'h0);
    `CHK("slverr", 1'b1, err)
    `CHK("rdzero", 32'h0, rd)
    end_test("pin_reset");
    final_report();
  end
endmodule
